// ---- hlt_timer.sv ----
// Hardware-limit one-shot timer core with register port and PWM drive.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
module hlt_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic timerTickEn,
    input wire logic external_trigger_in,
    input wire logic sleepActive,
    output logic pwmDrive,
    output logic periodMatchPulse,
    output logic oscKeepAlive
);
    // ==========================================================
    // Registers
    // ==========================================================
    // Control state written by software; the run bit is also cleared by hardware.
    logic runBit_q;          // Run bit, set by software, cleared by hardware too.
    logic [4:0] mode_q;      // Mode code.
    logic prescale_sync_select_q; // Sync select: 1 freezes timer in sleep.
    logic pwmSel_q;          // Route one-shot into the PWM drive.
    logic [7:0] period_limit_reg_q;
    logic [7:0] pulse_width_reg_q;
    logic [7:0] count_value_q;
    hlt_pkg::hlt_state_t state_q;
    logic trigMeta_q;        // First synchroniser stage, read only by the second.
    logic trigSync_q;        // Second stage.
    logic trigPrev_q;        // Previous synchronised level for edge detection.
    logic runPrev_q;         // Run bit last cycle, to see a fresh arm.

    // Mode decode.
    // Codes outside the five one-shot modes leave the timer idle for good.
    logic isEdgeMode;
    logic isLevelMode;
    assign isEdgeMode = (mode_q == hlt_pkg::MODE_EDGE_RISE) ||
                        (mode_q == hlt_pkg::MODE_EDGE_FALL) ||
                        (mode_q == hlt_pkg::MODE_EDGE_BOTH);
    assign isLevelMode = (mode_q == hlt_pkg::MODE_LVL_LOW) ||
                         (mode_q == hlt_pkg::MODE_LVL_HIGH);

    // ==========================================================
    // Trigger synchroniser
    // ==========================================================
    // The pin is sampled twice before use, so a slow or ragged edge is seen once.
    // Cost: a start is noticed three clocks after the pin moves.
    // A pin idling high gives one rise just after reset, while idle, so it is ignored.
    // R14: two-stage synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigMeta_q <= 1'b0;
            trigSync_q <= 1'b0;
            trigPrev_q <= 1'b0;
        end else begin
            trigMeta_q <= external_trigger_in;
            trigSync_q <= trigMeta_q;
            trigPrev_q <= trigSync_q;
        end
    end

    // Edge strobes last one cycle, as the third flop catches up on the next edge.
    logic riseEdge;
    logic fallEdge;
    assign riseEdge = trigSync_q && !trigPrev_q;
    assign fallEdge = !trigSync_q && trigPrev_q;

    // Level modes reuse the same strobes: leaving the reset level is the start edge.
    // R2: edge selection by mode
    logic startEdge;
    always_comb begin
        case (mode_q)
            hlt_pkg::MODE_EDGE_RISE: startEdge = riseEdge;
            hlt_pkg::MODE_EDGE_FALL: startEdge = fallEdge;
            hlt_pkg::MODE_EDGE_BOTH: startEdge = riseEdge || fallEdge;
            // R7: low reset level starts on rising transition.
            hlt_pkg::MODE_LVL_LOW: startEdge = riseEdge;
            hlt_pkg::MODE_LVL_HIGH: startEdge = fallEdge;
            default: startEdge = 1'b0;
        endcase
    end

    // The reset level acts in every state, so a held pin keeps the count at zero.
    // R7: reset level held by the external signal
    logic levelReset;
    assign levelReset = isLevelMode &&
                        ((mode_q == hlt_pkg::MODE_LVL_LOW) ? !trigSync_q : trigSync_q);

    // ==========================================================
    // Tick gating in sleep
    // ==========================================================
    // Gating the enable rather than the clock keeps the whole block on one clock.
    // R11: synchronised timer frozen in sleep
    logic tick;
    assign tick = timerTickEn && !(sleepActive && prescale_sync_select_q);
    // The oscillator control outside must honour oscKeepAlive for this to hold.
    // R12: unsynchronised timer keeps oscillator alive in sleep
    assign oscKeepAlive = sleepActive && !prescale_sync_select_q && runBit_q;

    // Period match while counting, seen on a tick.
    // Taking the match on a tick lets the count show the period value for a full tick.
    logic periodHit;
    assign periodHit = (state_q == hlt_pkg::ST_COUNT) && tick &&
                       (count_value_q == period_limit_reg_q);

    // ==========================================================
    // Run-state machine
    // ==========================================================
    // Every arm by software lands in ST_ARMED, so a fresh edge is always needed.
    // An edge in the cycle that follows the arm is lost, so software arms first.
    // A stop by software and a match both leave through the same idle state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= hlt_pkg::ST_IDLE;
        end else begin
            case (state_q)
                hlt_pkg::ST_IDLE: begin
                    // Only a known mode can arm; anything else stays idle.
                    if (runBit_q && (isEdgeMode || isLevelMode)) begin
                        state_q <= hlt_pkg::ST_ARMED;
                    end
                end
                hlt_pkg::ST_ARMED: begin
                    if (!runBit_q) begin
                        state_q <= hlt_pkg::ST_IDLE;
                    // R1: start only on the selected edge
                    end else if (startEdge) begin
                        state_q <= hlt_pkg::ST_COUNT;
                    end
                end
                hlt_pkg::ST_COUNT: begin
                    // R4: software stop returns to idle, requiring a new edge
                    // R9: period match also returns to idle
                    if (!runBit_q || periodHit) begin
                        state_q <= hlt_pkg::ST_IDLE;
                    end
                end
                default: state_q <= hlt_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Counter
    // ==========================================================
    // Priority: level reset, then period match, then counting, then the start clear.
    // The start clear makes every run begin at zero, whatever a stop left behind.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_value_q <= hlt_pkg::RST_COUNT;
        // R6: reset level holds the count at zero
        end else if (levelReset) begin
            count_value_q <= hlt_pkg::RST_COUNT;
        // R8: period match resets the count
        end else if (periodHit) begin
            count_value_q <= hlt_pkg::RST_COUNT;
        // R13: increment per enabled tick while counting
        end else if (state_q == hlt_pkg::ST_COUNT && runBit_q && tick) begin
            count_value_q <= count_value_q + 8'h01;
        end else if (state_q == hlt_pkg::ST_ARMED && startEdge) begin
            // Start from zero after any earlier software stop.
            count_value_q <= hlt_pkg::RST_COUNT;
        end
    end

    // ==========================================================
    // PWM drive
    // ==========================================================
    // Held in a flip-flop; it only rises on a start edge, never at period clear.
    // Clearing the run bit or the select drops the drive at once, which is safe.
    // Limitation: a pulse width above the period keeps the drive high to the match.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwmDrive <= 1'b0;
        end else if (!pwmSel_q || !runBit_q) begin
            pwmDrive <= 1'b0;
        // R5: start edge activates drive
        end else if (state_q == hlt_pkg::ST_ARMED && startEdge) begin
            pwmDrive <= 1'b1;
        // R10: pulse match or period match ends drive
        end else if (state_q == hlt_pkg::ST_COUNT &&
                     (count_value_q == pulse_width_reg_q || periodHit)) begin
            pwmDrive <= 1'b0;
        end
    end

    // Period-match strobe for the outside.
    // It follows the match by one cycle, when the count already reads zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periodMatchPulse <= 1'b0;
        end else begin
            periodMatchPulse <= periodHit;
        end
    end

    // ==========================================================
    // Register writes
    // ==========================================================
    // The hardware clear of the run bit loses to a software set in the same cycle.
    // Writes to the count and status places are dropped, as both are read only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runBit_q <= hlt_pkg::RST_CONTROL[hlt_pkg::CTL_RUN_BIT];
            mode_q <= hlt_pkg::RST_CONTROL[hlt_pkg::CTL_MODE_LSB +: 5];
            prescale_sync_select_q <= hlt_pkg::RST_CONTROL[hlt_pkg::CTL_SYNC_BIT];
            pwmSel_q <= hlt_pkg::RST_CONTROL[hlt_pkg::CTL_PWM_BIT];
        end else if (regWrEn && regAddr == hlt_pkg::ADDR_CONTROL) begin
            runBit_q <= regWrData[hlt_pkg::CTL_RUN_BIT];
            mode_q <= regWrData[hlt_pkg::CTL_MODE_LSB +: 5];
            prescale_sync_select_q <= regWrData[hlt_pkg::CTL_SYNC_BIT];
            pwmSel_q <= regWrData[hlt_pkg::CTL_PWM_BIT];
        // R3: period match clears the run bit
        end else if (periodHit) begin
            runBit_q <= 1'b0;
        end
    end

    // Period and pulse registers.
    // New values act on the next compare; a running count is not restarted.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_limit_reg_q <= hlt_pkg::RST_PERIOD;
            pulse_width_reg_q <= hlt_pkg::RST_PULSE;
        end else if (regWrEn) begin
            if (regAddr == hlt_pkg::ADDR_PERIOD) begin
                period_limit_reg_q <= regWrData;
            end
            if (regAddr == hlt_pkg::ADDR_PULSE) begin
                pulse_width_reg_q <= regWrData;
            end
        end
    end

    // ==========================================================
    // Register reads
    // ==========================================================
    // Data stand one cycle after the strobe; unmapped reads return zero.
    // Keeping the data at zero between reads makes a stale value easy to spot.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                hlt_pkg::ADDR_CONTROL:
                    regRdData <= {pwmSel_q, prescale_sync_select_q, mode_q, runBit_q};
                hlt_pkg::ADDR_PERIOD: regRdData <= period_limit_reg_q;
                hlt_pkg::ADDR_PULSE: regRdData <= pulse_width_reg_q;
                hlt_pkg::ADDR_COUNT: regRdData <= count_value_q;
                // Status packs the synchronised pin, the drive and the two run states.
                hlt_pkg::ADDR_STATUS:
                    regRdData <= {4'h0, trigSync_q, pwmDrive,
                                  state_q == hlt_pkg::ST_COUNT,
                                  state_q == hlt_pkg::ST_ARMED};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ==========================================================
    // Run-bit history
    // ==========================================================
    // The run bit one cycle late, kept only for the checks below.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runPrev_q <= 1'b0;
        end else begin
            runPrev_q <= runBit_q;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    // They are all off during reset, so no check sees a half-reset state.
    a_period_clears_run: assert property (@(posedge clk) disable iff (!rst_n) // R3
        periodHit && !(regWrEn && regAddr == hlt_pkg::ADDR_CONTROL) |=> !runBit_q)
        else $error("run bit not cleared at period match");
    a_edge_gates_start: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (state_q == hlt_pkg::ST_ARMED) && !startEdge |=> state_q != hlt_pkg::ST_COUNT)
        else $error("count started without edge");
    a_rise_mode_edge: assert property (@(posedge clk) disable iff (!rst_n) // R2
        mode_q == hlt_pkg::MODE_EDGE_RISE && fallEdge |-> !startEdge)
        else $error("falling edge started rising mode");
    a_rearm_needs_edge: assert property (@(posedge clk) disable iff (!rst_n) // R4
        runBit_q && !runPrev_q |-> state_q != hlt_pkg::ST_COUNT)
        else $error("resumed without fresh edge");
    a_pwm_start_edge: assert property (@(posedge clk) disable iff (!rst_n) // R5
        $rose(pwmDrive) |-> $past(startEdge) && $past(state_q) == hlt_pkg::ST_ARMED)
        else $error("drive rose without start edge");
    a_level_hold_zero: assert property (@(posedge clk) disable iff (!rst_n) // R6
        levelReset |=> count_value_q == 8'h00)
        else $error("count not held in reset level");
    a_period_count_zero: assert property (@(posedge clk) disable iff (!rst_n) // R8
        periodHit |=> count_value_q == 8'h00 && state_q == hlt_pkg::ST_IDLE)
        else $error("count not cleared at period match");
    a_no_rearm_period: assert property (@(posedge clk) disable iff (!rst_n) // R10
        periodHit |=> !pwmDrive)
        else $error("drive active after period match");
    a_sleep_freeze: assert property (@(posedge clk) disable iff (!rst_n) // R11
        sleepActive && prescale_sync_select_q && !levelReset && state_q != hlt_pkg::ST_ARMED
        |=> $stable(count_value_q))
        else $error("count moved in synced sleep");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n) // R13
        state_q == hlt_pkg::ST_COUNT && runBit_q && tick && !periodHit && !levelReset
        |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("count did not step by one");
    a_level_high_zero: assert property (@(posedge clk) disable iff (!rst_n) // R7
        mode_q == hlt_pkg::MODE_LVL_HIGH && trigSync_q |=> count_value_q == 8'h00)
        else $error("count moved at high reset level");
    a_level_low_zero: assert property (@(posedge clk) disable iff (!rst_n) // R6
        mode_q == hlt_pkg::MODE_LVL_LOW && !trigSync_q |=> count_value_q == 8'h00)
        else $error("count moved at low reset level");
    a_idle_no_count: assert property (@(posedge clk) disable iff (!rst_n) // R9
        state_q == hlt_pkg::ST_IDLE |=> state_q != hlt_pkg::ST_COUNT)
        else $error("count restarted without edge");
    a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n) // R13
        state_q == hlt_pkg::ST_IDLE && !levelReset |=> $stable(count_value_q))
        else $error("count moved while idle");
    a_start_clears: assert property (@(posedge clk) disable iff (!rst_n) // R13
        state_q == hlt_pkg::ST_ARMED && runBit_q && startEdge
        |=> state_q == hlt_pkg::ST_COUNT && count_value_q == 8'h00)
        else $error("start did not begin from zero");
    // Sleep checks: the enable gate is the only thing that may stop the count.
    a_sleep_counts: assert property (@(posedge clk) disable iff (!rst_n) // R12
        sleepActive && !prescale_sync_select_q && runBit_q && timerTickEn &&
        state_q == hlt_pkg::ST_COUNT && !periodHit && !levelReset
        |=> count_value_q == $past(count_value_q) + 8'h01)
        else $error("count stopped in unsynced sleep");
    a_osc_kept_on: assert property (@(posedge clk) disable iff (!rst_n) // R12
        sleepActive && !prescale_sync_select_q && runBit_q |-> oscKeepAlive)
        else $error("oscillator released in sleep");
    // The history guard keeps the check quiet while reset values drain out.
    a_sync_two_flops: assert property (@(posedge clk) disable iff (!rst_n) // R14
        $past(rst_n, 2) && $past(rst_n) |-> trigSync_q == $past(external_trigger_in, 2))
        else $error("trigger not delayed by two flops");
    a_pulse_end: assert property (@(posedge clk) disable iff (!rst_n) // R5
        state_q == hlt_pkg::ST_COUNT && count_value_q == pulse_width_reg_q |=> !pwmDrive)
        else $error("drive kept past pulse width");
    a_pwm_needs_run: assert property (@(posedge clk) disable iff (!rst_n) // R5
        !runBit_q |=> !pwmDrive)
        else $error("drive active with run bit clear");
    a_match_strobe: assert property (@(posedge clk) disable iff (!rst_n) // R3
        periodHit |=> periodMatchPulse)
        else $error("no strobe after period match");
endmodule : hlt_timer

// ---- hlt_pkg.sv ----
// Package of constants, modes and register map for the hardware-limit one-shot timer.
// Notes on behaviour
// R1: Edge one-shot counts only after trigger edge.
// R2: Modes 01001/01010/01011 pick rising/falling/either edge.
// R3: Period match clears run bit, halting timer.
// R4: Software stop needs fresh edge to resume.
// R5: Edge starts PWM; pulse match ends it.
// R6: Reset level holds count; transition starts count.
// R7: Modes 01110/01111 pick low/high reset level.
// R8: Level mode period match resets count, clears run.
// R9: Any run clear needs new edge to restart.
// R10: Level mode PWM not reactivated at period clear.
// R11: Prescale sync set freezes timer in sleep.
// R12: Sync clear counts in sleep; keeps oscillator on.
// R13: Count increments per tick from zero.
// R14: Trigger synchronised before edge and level detection.
package hlt_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] ADDR_CONTROL = 4'h0; // Run bit, mode, sync select, PWM select.
    localparam logic [3:0] ADDR_PERIOD = 4'h1;  // Period limit.
    localparam logic [3:0] ADDR_PULSE = 4'h2;   // Pulse width compare.
    localparam logic [3:0] ADDR_COUNT = 4'h3;   // Count value, read only.
    localparam logic [3:0] ADDR_STATUS = 4'h4;  // Armed, running, drive, trigger.
    // Control field positions.
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int CTL_SYNC_BIT = 6;
    localparam int CTL_PWM_BIT = 7;
    // ==========================================================
    // Mode codes
    // ==========================================================
    localparam logic [4:0] MODE_EDGE_RISE = 5'h09;
    localparam logic [4:0] MODE_EDGE_FALL = 5'h0a;
    localparam logic [4:0] MODE_EDGE_BOTH = 5'h0b;
    localparam logic [4:0] MODE_LVL_LOW = 5'h0e;
    localparam logic [4:0] MODE_LVL_HIGH = 5'h0f;
    // Reset values.
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_PULSE = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    // Run-state type.
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} hlt_state_t;
endpackage : hlt_pkg

// ---- hlt_trig_src.sv ----
// Partner model that drives the external trigger and reset signal into the timer.
module hlt_trig_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic levelReq,
    output logic external_trigger_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Trigger source
    // ==========================================================
    // The pin follows the request one edge late, like a pad that is driven from outside.
    // It ignores reset, because an external source does not see the timer's reset.
    always_ff @(posedge clk) begin
        external_trigger_in <= levelReq;
    end
endmodule : hlt_trig_src

// ---- hlt_tb.sv ----
// Self-checking testbench for the hardware-limit one-shot timer.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, timerTickEn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic trigLevel = 1'b0, extTrig, sleepActive = 1'b0, pwmDrive, periodMatchPulse;
    logic oscKeepAlive, rdWait = 1'b0, pre;
    logic [7:0] expQ[$]; // Expected read data, oldest first.
    logic [4:0] m;
    logic [7:0] expRd; // Oldest expected read value, taken off once per read.
    int bad_count = 0, comparisons = 0, cycles = 0, seed = 23, p, k, w;
    hlt_trig_src u_hlt_trig_src (.clk(clk), .rst_n(rst_n), .levelReq(trigLevel),
        .external_trigger_in(extTrig));
    hlt_timer u_hlt_timer (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .timerTickEn(timerTickEn),
        .external_trigger_in(extTrig), .sleepActive(sleepActive), .pwmDrive(pwmDrive),
        .periodMatchPulse(periodMatchPulse), .oscKeepAlive(oscKeepAlive));
    // Clock of 10 ns period.
    initial begin
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Bus tasks and helpers
    // ==========================================================
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk); regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
        @(posedge clk); regWrEn <= 1'b0;
    endtask : wr
    // A read only notes its expectation; the watcher below does the compare.
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk); regAddr <= a; regRdEn <= 1'b1; expQ.push_back(e);
        @(posedge clk); regRdEn <= 1'b0;
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // Gives n consecutive timer ticks.
    task automatic ticks(input int n);
        repeat (n) begin @(posedge clk); timerTickEn <= 1'b1; end
        @(posedge clk); timerTickEn <= 1'b0;
    endtask : ticks
    // Changes the trigger and waits past the synchroniser and start latency.
    task automatic trig(input logic v);
        @(posedge clk); trigLevel <= v;
        idle(8);
    endtask : trig
    // Waits, bounded, for the period-match pulse.
    task automatic waitMatch();
        for (int i = 0; i < 40 && periodMatchPulse !== 1'b1; i++) @(posedge clk);
    endtask : waitMatch
    function automatic logic [7:0] ctl(logic [4:0] md, logic r, logic s, logic pw);
        return {pw, s, md, r};
    endfunction : ctl
    task automatic finish_test();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // ==========================================================
    // Watcher: read data stands only in the cycle after the strobe
    // ==========================================================
    always @(posedge clk) begin
        if (rdWait) begin
            expRd = expQ.pop_front();
            `CHK(regRdData, expRd)
        end
        rdWait <= regRdEn;
    end
    // A hang is cut short well above the few hundred cycles that the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin bad_count++; finish_test(); end
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        idle(12);
        rst_n <= 1'b1;
        // Reset values, an unmapped place and a read-only count.
        rd(hlt_pkg::ADDR_CONTROL, hlt_pkg::RST_CONTROL);
        rd(hlt_pkg::ADDR_PERIOD, hlt_pkg::RST_PERIOD);
        rd(hlt_pkg::ADDR_PULSE, hlt_pkg::RST_PULSE);
        rd(4'h7, 8'h00);
        wr(hlt_pkg::ADDR_COUNT, 8'h55);
        rd(hlt_pkg::ADDR_COUNT, hlt_pkg::RST_COUNT);
        // Edge-started modes, with the drive output selected.
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? hlt_pkg::MODE_EDGE_RISE :
                (i == 1) ? hlt_pkg::MODE_EDGE_FALL : hlt_pkg::MODE_EDGE_BOTH;
            pre = (i == 1);
            p = 6 + ($unsigned($random(seed)) % 6);
            k = 1 + ($unsigned($random(seed)) % 3);
            w = k + 2;
            wr(hlt_pkg::ADDR_PERIOD, p[7:0]);
            wr(hlt_pkg::ADDR_PULSE, w[7:0]);
            trig(pre);
            wr(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b1, 1'b0, 1'b1));
            ticks(3);
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            trig(~pre);
            `CHK(pwmDrive, 1'b1)
            ticks(k);
            rd(hlt_pkg::ADDR_COUNT, k[7:0]);
            ticks(2);
            idle(2);
            `CHK(pwmDrive, 1'b0)
            ticks(p + 1 - w);
            waitMatch();
            `CHK(periodMatchPulse, 1'b1)
            rd(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b0, 1'b0, 1'b1));
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            `CHK(pwmDrive, 1'b0)
            // Re-arming without a fresh edge must not count.
            wr(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b1, 1'b0, 1'b0));
            ticks(3);
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            // Only the either-edge mode accepts the opposite edge.
            trig(pre);
            ticks(2);
            rd(hlt_pkg::ADDR_COUNT, (i == 2) ? 8'h02 : 8'h00);
            if (i == 2) ticks(p - 1);
            wr(hlt_pkg::ADDR_CONTROL, 8'h00);
        end
        // Level-reset modes.
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? hlt_pkg::MODE_LVL_LOW : hlt_pkg::MODE_LVL_HIGH;
            pre = (i == 1);
            wr(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b1, 1'b0, 1'b1));
            trig(pre);
            ticks(3);
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            trig(~pre);
            `CHK(pwmDrive, 1'b1)
            ticks(k);
            rd(hlt_pkg::ADDR_COUNT, k[7:0]);
            trig(pre);
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            trig(~pre);
            ticks(p + 1);
            waitMatch();
            `CHK(periodMatchPulse, 1'b1)
            rd(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b0, 1'b0, 1'b1));
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            `CHK(pwmDrive, 1'b0)
            wr(hlt_pkg::ADDR_CONTROL, ctl(m, 1'b1, 1'b0, 1'b0));
            ticks(3);
            rd(hlt_pkg::ADDR_COUNT, 8'h00);
            wr(hlt_pkg::ADDR_CONTROL, 8'h00);
        end
        // Sleep with synchronised prescaler freezes the count.
        trig(1'b0);
        wr(hlt_pkg::ADDR_CONTROL, ctl(hlt_pkg::MODE_EDGE_RISE, 1'b1, 1'b1, 1'b0));
        trig(1'b1);
        ticks(2);
        sleepActive <= 1'b1;
        ticks(3);
        `CHK(oscKeepAlive, 1'b0)
        rd(hlt_pkg::ADDR_COUNT, 8'h02);
        rd(hlt_pkg::ADDR_PERIOD, p[7:0]);
        sleepActive <= 1'b0;
        wr(hlt_pkg::ADDR_CONTROL, 8'h00);
        // Sleep without synchronisation keeps counting and the clock alive.
        trig(1'b0);
        wr(hlt_pkg::ADDR_CONTROL, ctl(hlt_pkg::MODE_EDGE_RISE, 1'b1, 1'b0, 1'b0));
        trig(1'b1);
        sleepActive <= 1'b1;
        ticks(2);
        `CHK(oscKeepAlive, 1'b1)
        rd(hlt_pkg::ADDR_COUNT, 8'h02);
        sleepActive <= 1'b0;
        // A software stop in mid-count holds the count until a fresh edge.
        wr(hlt_pkg::ADDR_CONTROL, ctl(hlt_pkg::MODE_EDGE_RISE, 1'b0, 1'b0, 1'b0));
        wr(hlt_pkg::ADDR_CONTROL, ctl(hlt_pkg::MODE_EDGE_RISE, 1'b1, 1'b0, 1'b0));
        ticks(3);
        rd(hlt_pkg::ADDR_COUNT, 8'h02);
        trig(1'b0);
        trig(1'b1);
        ticks(1);
        rd(hlt_pkg::ADDR_COUNT, 8'h01);
        idle(4);
        finish_test();
    end
endmodule : tb
